// ===== core/rdt_timer.sv
// Reload down-counter timer channel with APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rdt_timer
  (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic trigger_input_pin,
    // Events
    output logic irq,
    output logic io_service_req,
    input wire logic io_service_ack
  );
  import rdt_pkg::*;

  // ==========================================================
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit = (paddr == RDT_ADDR_COUNT) | (paddr == RDT_ADDR_CTRL) |
               (paddr == RDT_ADDR_ISTAT) | (paddr == RDT_ADDR_IMASK) |
               (paddr == RDT_ADDR_PRESC);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  logic [15:0] ctrl_reg;
  logic [15:0] reload_reg;
  logic [15:0] count_reg;
  logic [15:0] presc_reg;
  logic [15:0] pdiv_reg;
  logic imask_reg;
  logic tin_s1_reg;
  logic tin_s2_reg;
  logic tin_d_reg;
  rdt_state_t state_reg;
  rdt_state_t state_next;

  logic count_enable_bit;
  logic reload_select_bit;
  logic event_mode;
  logic edge_hit;
  logic sw_trig;
  logic trig;
  logic tick;
  logic uflow;
  logic wr_ctrl;
  logic wr_istat;
  logic stop_wr;

  assign wr_ctrl = wr_en & (paddr == RDT_ADDR_CTRL);
  assign wr_istat = wr_en & (paddr == RDT_ADDR_ISTAT);
  assign stop_wr = wr_ctrl & ~pwdata[RDT_B_COUNT_ENABLE_BIT];
  assign count_enable_bit = ctrl_reg[RDT_B_COUNT_ENABLE_BIT];
  assign reload_select_bit = ctrl_reg[RDT_B_RELOAD_SELECT_BIT];
  assign event_mode = ({ctrl_reg[RDT_B_MODE_SELECT_1], ctrl_reg[RDT_B_MODE_SELECT_0]} == RDT_MODE_EVENT) &
                      ~ctrl_reg[RDT_B_MODE_SELECT_2];

  // ==========================================================
  // Trigger pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tin_s1_reg <= 1'b0;
      tin_s2_reg <= 1'b0;
      tin_d_reg <= 1'b0;
    end
    else
    begin
      tin_s1_reg <= trigger_input_pin;
      tin_s2_reg <= tin_s1_reg;
      tin_d_reg <= tin_s2_reg;
    end
  end

  function automatic logic edge_match(input logic [1:0] sel, input logic cur, input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    unique case (sel)
      RDT_EDGE_NONE: edge_match = 1'b0;
      RDT_EDGE_RISE: edge_match = rise;
      RDT_EDGE_FALL: edge_match = fall;
      default: edge_match = rise | fall;
    endcase
  endfunction

  // Edge type from the two low mode bits
  assign edge_hit = edge_match({ctrl_reg[RDT_B_MODE_SELECT_1], ctrl_reg[RDT_B_MODE_SELECT_0]},
                               tin_s2_reg, tin_d_reg);
  // Trigger write with enable set in the same word also starts
  assign sw_trig = wr_ctrl & pwdata[RDT_B_TRG] & pwdata[RDT_B_COUNT_ENABLE_BIT];
  // Event mode uses edges as count clock, not as start
  // A write that clears the enable wins over a trigger; an underflow in reload mode in that cycle still reloads
  assign trig = (sw_trig | (count_enable_bit & edge_hit & ~event_mode)) & ~stop_wr;

  // ==========================================================
  // Count clock: prescaled internal or pin events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pdiv_reg <= RDT_PRESC_RST;
    else if (state_reg != RDT_ST_RUN || pdiv_reg == presc_reg)
      pdiv_reg <= RDT_PRESC_RST;
    else
      pdiv_reg <= pdiv_reg + 16'h0001;
  end
  assign tick = event_mode ? edge_hit : (pdiv_reg == presc_reg);
  assign uflow = (state_reg == RDT_ST_RUN) & tick & (count_reg == RDT_COUNT_RST);

  // ==========================================================
  // Counter state machine
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RDT_ST_STOP: if (trig) state_next = RDT_ST_RUN;
        else if (wr_ctrl && pwdata[RDT_B_COUNT_ENABLE_BIT]) state_next = RDT_ST_WAIT;
      RDT_ST_WAIT: if (trig) state_next = RDT_ST_RUN;
      // Retrigger in the underflow cycle keeps the counter running
      RDT_ST_RUN: if (uflow && !reload_select_bit && !trig) state_next = RDT_ST_WAIT;
      default: state_next = RDT_ST_STOP;
    endcase
    if (event_mode && count_enable_bit && state_reg == RDT_ST_WAIT && wr_ctrl && pwdata[RDT_B_TRG])
      state_next = RDT_ST_RUN;
    if (stop_wr)
      state_next = RDT_ST_STOP;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= RDT_ST_STOP;
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // Down counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= RDT_COUNT_RST;
    else if (trig)
      count_reg <= reload_reg;
    else if (state_reg == RDT_ST_RUN && tick)
    begin
      if (uflow && reload_select_bit)
        count_reg <= reload_reg;
      else if (uflow)
        count_reg <= RDT_ALL_ONES;
      else
        count_reg <= count_reg - 16'h0001;
    end
    // Otherwise held, incl. while disabled
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_reg <= RDT_RELOAD_RST;
    else if (wr_en && paddr == RDT_ADDR_COUNT)
      reload_reg <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_reg <= RDT_PRESC_RST;
      imask_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == RDT_ADDR_PRESC)
        presc_reg <= pwdata[15:0];
      if (wr_en && paddr == RDT_ADDR_IMASK)
        imask_reg <= pwdata[RDT_B_UF];
    end
  end

  // Trigger bit never stored, so it reads 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= RDT_CTRL_RST;
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_reg[15:3] <= pwdata[15:3] & RDT_CTRL_WMASK[15:3];
        ctrl_reg[RDT_B_COUNT_ENABLE_BIT] <= pwdata[RDT_B_COUNT_ENABLE_BIT];
      end
      // Set wins over any clear in the same cycle
      if (uflow)
        ctrl_reg[RDT_B_UF] <= 1'b1;
      else if ((wr_ctrl && !pwdata[RDT_B_UF]) || (wr_istat && pwdata[RDT_B_UF])
               || io_service_ack)
        ctrl_reg[RDT_B_UF] <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt and service request, own channel only
  assign irq = ctrl_reg[RDT_B_UF] & ctrl_reg[RDT_B_UNDERFLOW_IRQ_ENABLE] & ~imask_reg;
  assign io_service_req = ctrl_reg[RDT_B_UF] & ctrl_reg[RDT_B_UNDERFLOW_IRQ_ENABLE];

  // ==========================================================
  // Read mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        RDT_ADDR_COUNT: prdata[15:0] <= count_reg;
        RDT_ADDR_CTRL: prdata[15:0] <= ctrl_reg;
        RDT_ADDR_ISTAT: prdata[RDT_B_UF] <= ctrl_reg[RDT_B_UF];
        RDT_ADDR_IMASK: prdata[RDT_B_UF] <= imask_reg;
        RDT_ADDR_PRESC: prdata[15:0] <= presc_reg;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  // Counter path, irq level and trigger bit; reset disables every check
  a_uf_on_underflow: assert property (@(posedge pclk) disable iff (!presetn)
    uflow |=> ctrl_reg[RDT_B_UF])
    else $error("underflow did not set flag");
  a_oneshot_stops: assert property (@(posedge pclk) disable iff (!presetn)
    (uflow && !reload_select_bit && !trig) |=> count_reg == RDT_ALL_ONES && state_reg != RDT_ST_RUN)
    else $error("one-shot did not stop at ffff");
  a_reload_on_uf: assert property (@(posedge pclk) disable iff (!presetn)
    (uflow && reload_select_bit && !trig) |=> count_reg == $past(reload_reg))
    else $error("reload mode did not reload");
  a_hold_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RDT_ST_STOP && !trig) |=> $stable(count_reg))
    else $error("counter moved while stopped");
  a_trig_loads: assert property (@(posedge pclk) disable iff (!presetn)
    trig |=> count_reg == $past(reload_reg) && state_reg == RDT_ST_RUN)
    else $error("trigger did not load and start");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> ctrl_reg[RDT_B_UF] && ctrl_reg[RDT_B_UNDERFLOW_IRQ_ENABLE])
    else $error("irq without flag and enable");
  a_reload_wr_only: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == RDT_ADDR_COUNT && state_reg != RDT_ST_RUN && !trig)
    |=> $stable(count_reg))
    else $error("reload write touched counter");
  a_trg_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[RDT_B_TRG])
    else $error("trigger bit stored");
  a_run_decrement: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RDT_ST_RUN && tick && !uflow && !trig)
    |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("no decrement on tick");
  // Flag clearing, service request, states and read path
  a_uf_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !pwdata[RDT_B_UF] && !uflow) |=> !ctrl_reg[RDT_B_UF])
    else $error("writing zero did not clear flag");
  a_uf_clear_ack: assert property (@(posedge pclk) disable iff (!presetn)
    (io_service_ack && !uflow) |=> !ctrl_reg[RDT_B_UF])
    else $error("service start did not clear flag");
  a_uf_write_one: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[RDT_B_UF] && ctrl_reg[RDT_B_UF] && !io_service_ack)
    |=> ctrl_reg[RDT_B_UF])
    else $error("writing one changed flag");
  a_svc_on_uf: assert property (@(posedge pclk) disable iff (!presetn)
    (uflow && ctrl_reg[RDT_B_UNDERFLOW_IRQ_ENABLE] && !wr_ctrl) |=> io_service_req)
    else $error("underflow did not request service");
  a_count_enable_bit_stops: assert property (@(posedge pclk) disable iff (!presetn)
    stop_wr |=> state_reg == RDT_ST_STOP)
    else $error("clearing enable did not stop");
  a_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RDT_ST_WAIT && !trig) |=> $stable(count_reg))
    else $error("counter moved while waiting");
  a_event_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RDT_ST_RUN && event_mode && !edge_hit && !trig) |=> $stable(count_reg))
    else $error("event mode counted without edge");
  a_read_counter: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == RDT_ADDR_COUNT)
    |=> prdata[15:0] == $past(count_reg))
    else $error("counter read not live value");

endmodule // rdt_timer
`default_nettype wire

// ===== pkg/rdt_pkg.sv
// Constants and register map of the reload down-counter timer
`default_nettype none
package rdt_pkg;

  // ==========================================================
  // Register word indices; the shared index is not word aligned,
  // so every index sits at byte address four times the index
  localparam logic [11:0] RDT_IDX_COUNT = 12'h03a;
  localparam logic [11:0] RDT_IDX_CTRL = 12'h03c;
  localparam logic [11:0] RDT_IDX_ISTAT = 12'h040;
  localparam logic [11:0] RDT_IDX_IMASK = 12'h044;
  localparam logic [11:0] RDT_IDX_PRESC = 12'h048;

  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] RDT_ADDR_COUNT = {RDT_IDX_COUNT[9:0], 2'b00};
  localparam logic [11:0] RDT_ADDR_CTRL = {RDT_IDX_CTRL[9:0], 2'b00};
  localparam logic [11:0] RDT_ADDR_ISTAT = {RDT_IDX_ISTAT[9:0], 2'b00};
  localparam logic [11:0] RDT_ADDR_IMASK = {RDT_IDX_IMASK[9:0], 2'b00};
  localparam logic [11:0] RDT_ADDR_PRESC = {RDT_IDX_PRESC[9:0], 2'b00};

  // ==========================================================
  // Control/status bit positions
  localparam int RDT_B_TRG = 0;
  localparam int RDT_B_COUNT_ENABLE_BIT = 1;
  localparam int RDT_B_UF = 2;
  localparam int RDT_B_UNDERFLOW_IRQ_ENABLE = 3;
  localparam int RDT_B_RELOAD_SELECT_BIT = 4;
  localparam int RDT_B_OUTPUT_LEVEL_SELECT = 5;
  localparam int RDT_B_OUTPUT_PIN_ENABLE = 6;
  localparam int RDT_B_MODE_SELECT_0 = 7;
  localparam int RDT_B_MODE_SELECT_1 = 8;
  localparam int RDT_B_MODE_SELECT_2 = 9;
  localparam int RDT_B_CLOCK_SELECT_0 = 10;
  localparam int RDT_B_CLOCK_SELECT_1 = 11;
  localparam logic [15:0] RDT_CTRL_WMASK = 16'h0ffa;

  // ==========================================================
  // Reset values, all-ones value and event mode code
  localparam logic [15:0] RDT_CTRL_RST = 16'h0000;
  localparam logic [15:0] RDT_COUNT_RST = 16'h0000;
  localparam logic [15:0] RDT_RELOAD_RST = 16'h0000;
  localparam logic [15:0] RDT_PRESC_RST = 16'h0000;
  localparam logic [15:0] RDT_ALL_ONES = 16'hffff;
  localparam logic [1:0] RDT_MODE_EVENT = 2'b11;

  // Edge select codes
  localparam logic [1:0] RDT_EDGE_NONE = 2'b00;
  localparam logic [1:0] RDT_EDGE_RISE = 2'b01;
  localparam logic [1:0] RDT_EDGE_FALL = 2'b10;

  typedef enum logic [1:0] {
    RDT_ST_STOP = 2'b00,
    RDT_ST_WAIT = 2'b01,
    RDT_ST_RUN = 2'b10
  } rdt_state_t;

endpackage
`default_nettype wire

// ===== testbench/testbench.sv
// Register-level testbench of the reload down-counter timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rdt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin = 1'b0;
  logic irq;
  logic svc_req;
  logic svc_ack = 1'b0;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;

  rdt_timer uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_input_pin(pin),
    .irq(irq), .io_service_req(svc_req), .io_service_ack(svc_ack)
  );

  always #20 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  task automatic complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, always a full word; held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Bounded wait for the interrupt level
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'b0, irq}, 32'h0000_0001);
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    idle(4);
    presetn <= 1'b1;
    rdc(RDT_ADDR_CTRL, 32'h0000_0000);
    rdc(RDT_ADDR_COUNT, 32'h0000_0000);
    // Reload write leaves the counter alone; written whole, never read back
    wr(RDT_ADDR_COUNT, 32'h0000_0005);
    rdc(RDT_ADDR_COUNT, 32'h0000_0000);
    apb(1'b0, 12'h050, 32'h0000_0000);
    chk({31'b0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // Reload mode, software trigger
    wr(RDT_ADDR_CTRL, 32'h0000_001a);
    wr(RDT_ADDR_CTRL, 32'h0000_001b);
    apb(1'b0, RDT_ADDR_CTRL, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    wait_irq();
    chk({31'b0, svc_req}, 32'h0000_0001);
    idle(9);
    apb(1'b0, RDT_ADDR_COUNT, 32'h0000_0000);
    chk({31'b0, rd <= 32'h0000_0005}, 32'h0000_0001);
    // Stop: counter holds
    wr(RDT_ADDR_CTRL, 32'h0000_0018);
    apb(1'b0, RDT_ADDR_COUNT, 32'h0000_0000);
    idle(8);
    rdc(RDT_ADDR_COUNT, rd);
    wr(RDT_ADDR_ISTAT, 32'h0000_0004);
    idle(1);
    chk({31'b0, irq}, 32'h0000_0000);
    // One-shot stops at all ones
    wr(RDT_ADDR_CTRL, 32'h0000_000a);
    wr(RDT_ADDR_CTRL, 32'h0000_000b);
    wait_irq();
    idle(10);
    rdc(RDT_ADDR_COUNT, 32'h0000_ffff);
    wr(RDT_ADDR_CTRL, 32'h0000_000e);
    idle(1);
    chk({31'b0, irq}, 32'h0000_0001);
    wr(RDT_ADDR_IMASK, 32'h0000_0004);
    idle(1);
    chk({31'b0, irq}, 32'h0000_0000);
    chk({31'b0, svc_req}, 32'h0000_0001);
    svc_ack <= 1'b1;
    idle(1);
    svc_ack <= 1'b0;
    idle(2);
    chk({31'b0, svc_req}, 32'h0000_0000);
    wr(RDT_ADDR_IMASK, 32'h0000_0000);
    // Rising pin edge as start trigger
    wr(RDT_ADDR_CTRL, 32'h0000_0000);
    wr(RDT_ADDR_COUNT, 32'h0000_0003);
    wr(RDT_ADDR_CTRL, 32'h0000_008a);
    idle(10);
    rdc(RDT_ADDR_COUNT, 32'h0000_ffff);
    pin <= 1'b1;
    wait_irq();
    wr(RDT_ADDR_CTRL, 32'h0000_0000);
    rdc(RDT_ADDR_CTRL, 32'h0000_0000);
    chk({31'b0, irq}, 32'h0000_0000);
    // Event count: only pin edges decrement
    wr(RDT_ADDR_COUNT, 32'h0000_0002);
    wr(RDT_ADDR_CTRL, 32'h0000_019a);
    wr(RDT_ADDR_CTRL, 32'h0000_019b);
    idle(10);
    rdc(RDT_ADDR_COUNT, 32'h0000_0002);
    repeat (3)
    begin
      pin <= ~pin;
      idle(6);
    end
    wait_irq();
    // Falling pin edge only, prescaled count clock of eight cycles
    wr(RDT_ADDR_CTRL, 32'h0000_0000);
    wr(RDT_ADDR_COUNT, 32'h0000_0001);
    wr(RDT_ADDR_PRESC, 32'h0000_0007);
    rdc(RDT_ADDR_PRESC, 32'h0000_0007);
    wr(RDT_ADDR_CTRL, 32'h0000_010a);
    pin <= 1'b1;
    idle(10);
    rdc(RDT_ADDR_COUNT, 32'h0000_0002);
    pin <= 1'b0;
    idle(5);
    rdc(RDT_ADDR_COUNT, 32'h0000_0001);
    wait_irq();
    rdc(RDT_ADDR_COUNT, 32'h0000_ffff);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
